// ===== hw/msr_bank_regs.vh
// Register indexes, field positions and reset values of the model register bank
`ifndef MSR_BANK_REGS_VH
`define MSR_BANK_REGS_VH
// Model register indexes as seen in the index register
`define IDX_MC_ADDR       32'h00000000
`define IDX_MC_TYPE       32'h00000001
`define IDX_CACHE_TEST    32'h0000000E
`define IDX_CYCLE_COUNT   32'h00000010
`define IDX_WRITE_HANDLE  32'hC0000082
// Write handling control fields
`define WH_HOLE_EN_BIT    0
`define WH_LIMIT_LO       1
`define WH_LIMIT_HI       7
`define WH_COMB_DIS_BIT   8
`define WH_WIDTH          9
// Cache test control: disable bit position and stored width
`define CT_CACHE_DIS_BIT  3
`define CT_WIDTH          32
// Debug register selects
`define DBG_BKPT_ZERO     3'h0
`define DBG_BKPT_THREE    3'h3
`define DBG_RSVD_FOUR     3'h4
`define DBG_RSVD_FIVE     3'h5
// Reset values
`define MC_RESET          64'h0000000000000000
`define CT_RESET          32'h00000000
`define WH_RESET          9'h000
`define CNT_RESET         64'h0000000000000000
`define BKPT_RESET        32'h00000000
`define ZERO32            32'h00000000
`endif

// ===== hw/cycle_counter_unit.v
// Free-running 64-bit cycle counter with software load
module cycle_counter_unit #(
    parameter WIDTH = 64
) (
    input  wire             sys_clk,
    input  wire             sys_rst,
    input  wire             load,
    input  wire [WIDTH-1:0] loadValue,
    output reg  [WIDTH-1:0] count_r
);
`include "msr_bank_regs.vh"

    // Count every clock; a write replaces the count and counting resumes from it
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_r <= `CNT_RESET;
        end else if (load) begin
            count_r <= loadValue;
        end else begin
            // Plain add wraps from all ones to zero on its own
            count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

// ===== hw/msr_debug_register_bank.v
// Model register bank with breakpoint debug registers
//
// Operation
// - Index register selects one of five model registers
// - Index 00h machine-check address, 01h type
// - 0Eh cache test, 10h counter, C000_0082h write-handling
// - Data moves through low and high data registers
// - Machine-check exception is never raised
// - Machine-check registers change only on write or reset
// - Cache test register can disable level-one caches
// - Cycle counter increments every clock except when a write loads it
// - Allocate limit bits 7-1, hole enable bit 0
// - Four breakpoint registers hold 32-bit linear addresses
// - Fifth and sixth debug registers are reserved
// - Write-handling register clears to zero on reset
module msr_debug_register_bank #(
    parameter NUM_BKPT = 4
) (
    input  wire                     sys_clk,
    input  wire                     sys_rst,
    input  wire [31:0]              indexReg,
    input  wire [31:0]              lowDataIn,
    input  wire [31:0]              highDataIn,
    input  wire                     readInstr,
    input  wire                     writeInstr,
    output reg  [31:0]              lowDataOut_r,
    output reg  [31:0]              highDataOut_r,
    output reg                      readDone_r,
    output reg                      writeDone_r,
    output reg                      accessFault_r,
    input  wire [2:0]               debugSel,
    input  wire                     debugRead,
    input  wire                     debugWrite,
    input  wire [31:0]              debugWriteData,
    output reg  [31:0]              debugReadData_r,
    output reg                      debugReadDone_r,
    output reg  [NUM_BKPT*32-1:0]   bkptAddrs_r,
    output reg                      cacheDisable_r,
    output reg  [6:0]               writeAllocLimit_r,
    output reg                      writeAllocHoleEn_r,
    output reg                      machineCheckRaise_r
);
`include "msr_bank_regs.vh"

    // Interface overview
    //
    // Model register port
    //   A request is one clock wide: readInstr or writeInstr high at a rising
    //   edge, with indexReg and both data words valid at that same edge.
    //   The index is decoded in the same cycle, so nothing is pipelined ahead
    //   of the strobe and a new request may follow on the very next edge.
    //   One edge later exactly one of readDone_r, writeDone_r or accessFault_r
    //   pulses for one cycle. Read data is loaded into lowDataOut_r and
    //   highDataOut_r at that edge and then holds until the next read.
    //
    // Write priority
    //   When both strobes stand together the write is carried out and the
    //   read is dropped. Giving the write priority keeps a stored register
    //   from being read and overwritten in one edge with no clear ordering.
    //
    // Unknown indexes
    //   Any index other than the five decoded ones changes no storage and
    //   answers with a fault pulse. A read of such an index still loads the
    //   data outputs, with zero, so stale data never looks like an answer.
    //
    // Partial registers
    //   The cache test register keeps only its low word and the write
    //   handling register only its low nine bits; all other bits read zero.
    //   This saves flops at the cost of not echoing reserved bits back.
    //
    // Counter
    //   A read returns the count as it stood at the strobe edge, before the
    //   increment of that edge. A write replaces the count at the strobe edge
    //   and counting resumes from the written value on the next edge.
    //
    // Debug port
    //   debugSel picks a debug position. Positions 0 to 3 are breakpoint
    //   address registers, positions 4 and 5 are reserved, 6 and 7 unused.
    //   Reads answer one edge later with debugReadDone_r; writes show on
    //   bkptAddrs_r one edge later. Writes to any other position are lost.
    //
    // Reset
    //   sys_rst is asynchronous and clears every stored register and every
    //   output flop, so all outputs are zero during reset and at the first
    //   edge after it is released.

    // Stored model registers
    reg  [63:0]                machineCheckAddr_r;  // Changed only by a write or reset
    reg  [63:0]                machineCheckType_r;  // Changed only by a write or reset
    reg  [`CT_WIDTH-1:0]       cacheTestCtrl_r;     // Low word of cache test
    reg  [`WH_WIDTH-1:0]       writeHandleCtrl_r;   // Bits 8..0; rest reserved
    wire [63:0]                cycleCount;          // From counter unit

    // Index decode strobes
    reg                        hitMcAddr;
    reg                        hitMcType;
    reg                        hitCacheTest;
    reg                        hitCycle;
    reg                        hitWriteHandle;
    reg                        hitAny;

    // Write wins when both instruction strobes arrive together
    wire                       doWrite;
    wire                       doRead;
    wire [63:0]                writeWord;

    assign doWrite   = writeInstr;
    assign doRead    = readInstr & ~writeInstr;
    assign writeWord = {highDataIn, lowDataIn};

    // Decode the index register into one select per model register
    always @* begin
        hitMcAddr      = 1'b0;
        hitMcType      = 1'b0;
        hitCacheTest   = 1'b0;
        hitCycle       = 1'b0;
        hitWriteHandle = 1'b0;
        if (indexReg == `IDX_MC_ADDR) begin
            hitMcAddr = 1'b1;
        end else if (indexReg == `IDX_MC_TYPE) begin
            hitMcType = 1'b1;
        end else if (indexReg == `IDX_CACHE_TEST) begin
            hitCacheTest = 1'b1;
        end else if (indexReg == `IDX_CYCLE_COUNT) begin
            hitCycle = 1'b1;
        end else if (indexReg == `IDX_WRITE_HANDLE) begin
            hitWriteHandle = 1'b1;
        end
        hitAny = hitMcAddr | hitMcType | hitCacheTest | hitCycle | hitWriteHandle;
    end

    // Read multiplexer; reserved and unstored bits read as zero
    reg  [63:0]                readWord;
    always @* begin
        readWord = 64'h0000000000000000;
        if (hitMcAddr) begin
            readWord = machineCheckAddr_r;
        end else if (hitMcType) begin
            readWord = machineCheckType_r;
        end else if (hitCacheTest) begin
            readWord = {`ZERO32, cacheTestCtrl_r};
        end else if (hitCycle) begin
            readWord = cycleCount;
        end else if (hitWriteHandle) begin
            readWord = {55'h0, writeHandleCtrl_r};
        end
    end

    // Cycle counter lives in its own unit; a write loads it.
    // Keeping it apart lets the adder be placed and timed on its own,
    // since a 64-bit carry chain is the longest path in this block.
    // Load has priority over the increment inside the unit.
    cycle_counter_unit #(
        .WIDTH     (64)
    ) cycle_counter_unit_i (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .load      (doWrite & hitCycle),
        .loadValue (writeWord),
        .count_r   (cycleCount)
    );

    // Machine-check registers: only a write or reset touches them.
    // No error source feeds them, since no machine check is ever generated.
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            machineCheckAddr_r <= `MC_RESET;
            machineCheckType_r <= `MC_RESET;
        end else begin
            if (doWrite && hitMcAddr) begin
                machineCheckAddr_r <= writeWord;
            end
            if (doWrite && hitMcType) begin
                machineCheckType_r <= writeWord;
            end
        end
    end

    // Exception request is tied off in a flop; the enable bit has no effect here
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            machineCheckRaise_r <= 1'b0;
        end else begin
            machineCheckRaise_r <= 1'b0;
        end
    end

    // Cache test and write-handling control registers
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cacheTestCtrl_r   <= `CT_RESET;
            writeHandleCtrl_r <= `WH_RESET;
        end else begin
            if (doWrite && hitCacheTest) begin
                // Upper half is not stored, so it reads back zero
                cacheTestCtrl_r <= lowDataIn;
            end
            if (doWrite && hitWriteHandle) begin
                // Combining-disable bit is stored as written; software must keep it zero
                writeHandleCtrl_r <= lowDataIn[`WH_WIDTH-1:0];
            end
        end
    end

    // Control outputs steered by the model registers
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cacheDisable_r     <= 1'b0;
            writeAllocLimit_r  <= 7'h00;
            writeAllocHoleEn_r <= 1'b0;
        end else begin
            cacheDisable_r     <= cacheTestCtrl_r[`CT_CACHE_DIS_BIT];
            writeAllocLimit_r  <= writeHandleCtrl_r[`WH_LIMIT_HI:`WH_LIMIT_LO];
            writeAllocHoleEn_r <= writeHandleCtrl_r[`WH_HOLE_EN_BIT];
        end
    end

    // Instruction answer: data and done pulses one edge after the strobe.
    // An index outside the five gives a fault pulse, and zero data on a read.
    // The pulses are mutually exclusive: a known index gives a done pulse
    // of the matching kind, an unknown one only the fault pulse.
    // Data outputs change only on a read, so a following write leaves the
    // last read result in place for software to collect later.
    // No wait states are ever inserted; every request is answered in one.
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lowDataOut_r  <= `ZERO32;
            highDataOut_r <= `ZERO32;
            readDone_r    <= 1'b0;
            writeDone_r   <= 1'b0;
            accessFault_r <= 1'b0;
        end else begin
            readDone_r    <= doRead & hitAny;
            writeDone_r   <= doWrite & hitAny;
            accessFault_r <= (doRead | doWrite) & ~hitAny;
            if (doRead) begin
                // Read returns into the low and high data registers
                lowDataOut_r  <= readWord[31:0];
                highDataOut_r <= readWord[63:32];
            end
        end
    end

    // Breakpoint linear-address registers, one per breakpoint.
    // Each breakpoint is a full 32-bit word with no reserved bits, so a
    // write stores every bit and a read returns it unchanged.
    // The registers only hold addresses here; matching them against
    // fetches and data accesses is done elsewhere in the core.
    // One generate entry per breakpoint keeps the count a parameter.
    genvar g;
    generate
        for (g = 0; g < NUM_BKPT; g = g + 1) begin : bkpt
            always @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    bkptAddrs_r[g*32 +: 32] <= `BKPT_RESET;
                end else if (debugWrite && debugSel == g) begin
                    bkptAddrs_r[g*32 +: 32] <= debugWriteData;
                end
            end
        end
    endgenerate

    // Debug register reads; reserved positions and others read zero.
    // The reserved positions have no storage at all, which is cheaper
    // than keeping flops whose contents would never be used.
    // Read data holds between reads, like the model register outputs.
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            debugReadData_r <= `ZERO32;
            debugReadDone_r <= 1'b0;
        end else begin
            debugReadDone_r <= debugRead;
            if (debugRead) begin
                if (debugSel <= `DBG_BKPT_THREE) begin
                    debugReadData_r <= bkptAddrs_r[debugSel[1:0]*32 +: 32];
                end else begin
                    // Writes to reserved positions are dropped; reads give zero
                    debugReadData_r <= `ZERO32;
                end
            end
        end
    end
endmodule

// ===== test/msr_bank_asserts.sv
// Port-level checks of the model register bank
`include "msr_bank_regs.vh"
module msr_bank_asserts (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic [31:0] indexReg,
    input wire logic [31:0] lowDataIn,
    input wire logic        readInstr,
    input wire logic        writeInstr,
    input wire logic        readDone_r,
    input wire logic        writeDone_r,
    input wire logic        accessFault_r,
    input wire logic        debugRead,
    input wire logic        debugReadDone_r,
    input wire logic        cacheDisable_r,
    input wire logic        machineCheckRaise_r
);
    // High when the index names one of the five registers
    wire idxOk = indexReg == `IDX_MC_ADDR || indexReg == `IDX_MC_TYPE || indexReg == `IDX_CACHE_TEST
                 || indexReg == `IDX_CYCLE_COUNT || indexReg == `IDX_WRITE_HANDLE;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_never_machine_check: assert property (machineCheckRaise_r == 1'h0) else $error("machine check raised");
    a_write_taken: assert property (writeInstr && idxOk |=> writeDone_r && !accessFault_r)
        else $error("write not answered");
    a_bad_index_fault: assert property ((readInstr || writeInstr) && !idxOk |=> accessFault_r && !writeDone_r)
        else $error("bad index not refused");
    a_read_answered: assert property (readInstr && !writeInstr && idxOk |=> readDone_r) else $error("read lost");
    a_write_wins: assert property (writeInstr |=> !readDone_r) else $error("read done beside write");
    a_read_cause: assert property (readDone_r |-> $past(readInstr) && !$past(writeInstr))
        else $error("read done without request");
    a_debug_answered: assert property (debugRead |=> debugReadDone_r) else $error("debug read lost");
    a_cache_disable: assert property (writeInstr && indexReg == `IDX_CACHE_TEST ##1 !writeInstr
        |=> cacheDisable_r == $past(lowDataIn[`CT_CACHE_DIS_BIT], 2)) else $error("cache disable wrong");
    cover property (readDone_r);
    cover property (accessFault_r);
    cover property (debugReadDone_r);
endmodule
bind msr_debug_register_bank msr_bank_asserts msr_bank_asserts_i (.*);

// ===== test/tb_msr_debug_register_bank.sv
// Self-checking bench for the model register bank
`include "msr_bank_regs.vh"
module tb_msr_debug_register_bank;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'h0;
    logic        sys_rst = 1'h1;
    logic [31:0] indexReg = '0, lowDataIn = '0, highDataIn = '0, debugWriteData = '0;
    logic        readInstr = 1'h0, writeInstr = 1'h0, debugRead = 1'h0, debugWrite = 1'h0;
    logic [2:0]  debugSel = 3'h0;
    wire  [31:0] lowDataOut_r, highDataOut_r, debugReadData_r;
    wire  [127:0] bkptAddrs_r;
    wire  [6:0]  writeAllocLimit_r;
    wire         readDone_r, writeDone_r, accessFault_r, debugReadDone_r;
    wire         cacheDisable_r, writeAllocHoleEn_r, machineCheckRaise_r;
    wire  [63:0] rdData = {highDataOut_r, lowDataOut_r};  // Read data as one word
    int          failCount = 0, testsRun = 0, seed = 9, k;
    time         edgeT, t0;                               // Sampling edge of the last access
    logic [63:0] model [0:4];                             // Expected register contents
    logic [63:0] d;
    logic [31:0] idx, dw;
    logic [31:0] idxTab [0:4] = '{`IDX_MC_ADDR, `IDX_MC_TYPE, `IDX_CACHE_TEST, `IDX_CYCLE_COUNT, `IDX_WRITE_HANDLE};
    msr_debug_register_bank msr_debug_register_bank_i (.*);
    always #5 sys_clk = ~sys_clk;  // 10 ns period
    // Slot of an index in the model, 5 for none
    function automatic int slot(logic [31:0] i);
        for (int s = 0; s < 5; s++)
            if (idxTab[s] == i) return s;
        return 5;
    endfunction
    // What a register keeps of a written word
    function automatic logic [63:0] stored(int s, logic [63:0] v);
        if (s == 2) return {32'h0, v[31:0]};
        if (s == 4) return {55'h0, v[8:0]};
        return v;
    endfunction
    task automatic check(logic [63:0] got, logic [63:0] exp);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One model register access; the answer lands one cycle on
    task automatic msr(logic wr, logic [31:0] i, logic [63:0] v);
        indexReg <= i;
        {highDataIn, lowDataIn} <= v;
        writeInstr <= wr;
        readInstr <= !wr;
        @(posedge sys_clk);
        edgeT = $time;
        writeInstr <= 1'h0;
        readInstr <= 1'h0;
        #1;
        check(accessFault_r, slot(i) == 5);
    endtask
    task automatic dbg(logic wr, logic [2:0] sel, logic [31:0] v);
        debugSel <= sel;
        debugWriteData <= v;
        debugWrite <= wr;
        debugRead <= !wr;
        @(posedge sys_clk);
        debugWrite <= 1'h0;
        debugRead <= 1'h0;
        #1;
    endtask
    // Stored registers must read zero after reset
    task automatic resetCheck;
        for (int s = 0; s < 5; s++) model[s] = 64'h0;
        for (int s = 0; s < 5; s++)
            if (s != 3) begin
                msr(1'h0, idxTab[s], 64'h0);
                check(rdData, 64'h0);
            end
    endtask
    task automatic printVerdict;
        $display("comparisons %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Cuts a hang short
    initial begin
        #200000;
        failCount++;
        printVerdict;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'h0;
        resetCheck;
        // Random writes and read-backs, bad indexes among them
        for (int n = 0; n < 40; n++) begin
            k = {$random(seed)} % 6;
            idx = (k == 5) ? ($random(seed) | 32'h100) : idxTab[k == 3 ? 4 : k];
            d = {$random(seed), $random(seed)};
            if (slot(idx) == 4) d[8] = 1'h0;
            msr(1'h1, idx, d);
            if (slot(idx) < 5) model[slot(idx)] = stored(slot(idx), d);
            msr(1'h0, idx, 64'h0);
            check(rdData, slot(idx) < 5 ? model[slot(idx)] : 64'h0);
            check(cacheDisable_r, model[2][3]);
            check({writeAllocLimit_r, writeAllocHoleEn_r}, model[4][7:0]);
        end
        // Counter load near the top, then wrap
        msr(1'h1, `IDX_CYCLE_COUNT, 64'hFFFFFFFFFFFFFFFE);
        t0 = edgeT;
        repeat (2) @(posedge sys_clk);
        msr(1'h0, `IDX_CYCLE_COUNT, 64'h0);
        check(rdData, 64'hFFFFFFFFFFFFFFFE + (edgeT - t0) / 10 - 1);
        // Breakpoints hold addresses, reserved places read zero
        for (int b = 0; b < 6; b++) begin
            dw = $random(seed);
            dbg(1'h1, b, dw);
            dbg(1'h0, b, 32'h0);
            check(debugReadData_r, b < 4 ? dw : 32'h0);
            if (b < 4) check(bkptAddrs_r[32*b +: 32], dw);
        end
        sys_rst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'h0;
        resetCheck;
        check(machineCheckRaise_r, 1'h0);
        printVerdict;
    end
endmodule
